// *** rtl/sram_host.v ***
`timescale 1ns/1ps
`include "sram_host_defines.vh"
module sram_host #(
    parameter ADDR_W = 8,
    parameter SETUP_CYC = `SETUP_CYC,
    parameter STROBE_CYC = `STROBE_CYC,
    parameter HOLD_CYC = `HOLD_CYC,
    parameter ACCESS_CYC = `ACCESS_CYC
) (
    input wire sys_clk,
    input wire srst,
    input wire reqValid,
    input wire [1:0] reqOp,
    input wire [ADDR_W-1:0] reqAddr,
    input wire reqData,
    output reg reqReady,
    output reg rspValid,
    output reg rspData,
    output reg [ADDR_W-1:0] wordSelect,
    output reg dataIn,
    output reg direction,
    output reg chipSelectNFirst,
    output reg chipSelectNSecond,
    output reg chipSelectNThird,
    input wire memOut,
    input wire memOutEnN
);
    // Each phase runs for its own count of clocks
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_ACCESS = 3'h2;
    localparam S_STROBE = 3'h3;
    localparam S_HOLD = 3'h4;
    localparam S_DONE = 3'h5;
    localparam CNT_W = 16;

    reg [2:0] state;
    reg [1:0] op;
    reg [CNT_W-1:0] count;

    reg [2:0] next_state;
    reg [1:0] next_op;
    reg [CNT_W-1:0] next_count;
    reg next_reqReady;
    reg next_rspValid;
    reg next_rspData;
    reg [ADDR_W-1:0] next_wordSelect;
    reg next_dataIn;
    reg next_direction;
    reg next_selectN;

    // A zero load would skip the end test and run the count round
    function [CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = (n < 1) ? 16'h0001 : n[CNT_W-1:0];
        end
    endfunction

    function lastCycle;
        input [CNT_W-1:0] c;
        begin
            lastCycle = (c == 16'h0001);
        end
    endfunction

    function [CNT_W-1:0] countDown;
        input [CNT_W-1:0] c;
        begin
            countDown = c - 16'h0001;
        end
    endfunction

    function isWrite;
        input [1:0] o;
        begin
            isWrite = (o == `OP_WRITE);
        end
    endfunction

    function isRmw;
        input [1:0] o;
        begin
            isRmw = (o == `OP_RMW);
        end
    endfunction

    // Every path starts from the present value, or zero for rspValid, so nothing latches
    always @* begin
        next_state = state;
        next_op = op;
        next_count = count;
        next_reqReady = reqReady;
        next_rspValid = 1'h0;
        next_rspData = rspData;
        next_wordSelect = wordSelect;
        next_dataIn = dataIn;
        next_direction = direction;
        next_selectN = chipSelectNFirst;
        case (state)
            S_IDLE: begin
                next_reqReady = 1'h1;
                // Address only moves while selects are high
                if (reqValid && reqReady) begin
                    next_reqReady = 1'h0;
                    next_op = reqOp;
                    next_wordSelect = reqAddr; // RULE6 RULE10 RULE1
                    next_dataIn = reqData;
                    // Reads set direction high before select
                    next_direction = !isWrite(reqOp); // RULE11
                    next_count = cyc(SETUP_CYC);
                    next_state = S_SETUP;
                end
            end
            S_SETUP: begin
                if (lastCycle(count)) begin
                    next_selectN = 1'h0; // RULE2 RULE7
                    if (isWrite(op)) begin
                        next_count = cyc(STROBE_CYC);
                        next_state = S_STROBE;
                    end else begin
                        next_count = cyc(ACCESS_CYC);
                        next_state = S_ACCESS;
                    end
                end else begin
                    next_count = countDown(count);
                end
            end
            S_ACCESS: begin
                if (!lastCycle(count)) begin
                    next_count = countDown(count);
                    // Last cycle waits until the device drives its line;
                    // a device that never drives stalls the access here
                end else if (!memOutEnN) begin
                    // Device returns the inverse; undo it here
                    next_rspData = ~memOut; // RULE4
                    if (isRmw(op)) begin
                        next_direction = 1'h0; // RULE12
                        next_count = cyc(STROBE_CYC);
                        next_state = S_STROBE;
                    end else begin
                        next_selectN = 1'h1; // RULE11
                        next_count = cyc(HOLD_CYC);
                        next_state = S_HOLD;
                    end
                end
            end
            S_STROBE: begin
                if (lastCycle(count)) begin
                    // Selects end the overlap; data held after
                    next_selectN = 1'h1; // RULE7 RULE8
                    next_count = cyc(HOLD_CYC);
                    next_state = S_HOLD;
                end else begin
                    next_count = countDown(count);
                end
            end
            S_HOLD: begin
                if (lastCycle(count)) begin
                    // Direction rises only once the selects are high
                    next_direction = 1'h1; // RULE11
                    next_rspValid = 1'h1;
                    next_state = S_DONE;
                end else begin
                    next_count = countDown(count);
                end
            end
            S_DONE: begin
                // Idle cycle keeps two takes at least two edges apart
                next_reqReady = 1'h1;
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            state <= S_IDLE;
            op <= `OP_READ;
            count <= 16'h0000;
        end else begin
            state <= next_state;
            op <= next_op;
            count <= next_count;
        end
    end

    // rspData is a level and stands until the next read samples the device line
    always @(posedge sys_clk) begin
        if (srst) begin
            reqReady <= 1'h0;
            rspValid <= 1'h0;
            rspData <= 1'h0;
        end else begin
            reqReady <= next_reqReady;
            rspValid <= next_rspValid;
            rspData <= next_rspData;
        end
    end

    // Reset leaves the selects high and direction at read, so the
    // device can neither be written nor drive its line out of reset
    always @(posedge sys_clk) begin
        if (srst) begin
            wordSelect <= {ADDR_W{1'h0}};
            dataIn <= 1'h0;
            direction <= 1'h1;
            chipSelectNFirst <= 1'h1;
            chipSelectNSecond <= 1'h1;
            chipSelectNThird <= 1'h1;
        end else begin
            wordSelect <= next_wordSelect;
            dataIn <= next_dataIn;
            direction <= next_direction;
            chipSelectNFirst <= next_selectN; // RULE7
            chipSelectNSecond <= next_selectN;
            chipSelectNThird <= next_selectN;
        end
    end
endmodule // sram_host

// *** rtl/sram_host_defines.vh ***
// Behaviour
// RULE1 - 256 one-bit words, fully address decoded
// RULE2 - Write when all selects and direction low
// RULE3 - Direction low keeps device output off
// RULE4 - Read returns inverse of stored bit
// RULE5 - Any select high: output off, no write
// RULE6 - Hold a select high while address changes
// RULE7 - Write interval is the select/direction overlap
// RULE8 - Data stable around end of write overlap
// RULE9 - Off output neither sources nor sinks current (model still drives the stored bit on memOut while off)
// RULE10 - Address stable across whole select window
// RULE11 - Direction high before and after read selects
// RULE12 - Read-modify-write with selects held low
// RULE13 - Contents retained; reads do not disturb
`ifndef SRAM_HOST_DEFINES_VH
`define SRAM_HOST_DEFINES_VH
`define CLK_PERIOD_NS 25
`define SETUP_NS 100
`define STROBE_NS 200
`define HOLD_NS 100
`define ACCESS_NS 500
`define CYC_OF(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC `CYC_OF(`SETUP_NS)
`define STROBE_CYC `CYC_OF(`STROBE_NS)
`define HOLD_CYC `CYC_OF(`HOLD_NS)
`define ACCESS_CYC `CYC_OF(`ACCESS_NS)
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_RMW 2'h2
`endif

// *** verif/sram_host_assertions.sv ***
`timescale 1ns/1ps
module sram_host_checker (
    input wire sys_clk,
    input wire srst,
    input wire [7:0] wordSelect,
    input wire dataIn,
    input wire direction,
    input wire chipSelectNFirst
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    addr_change_a: assert property ($changed(wordSelect) |->
        chipSelectNFirst && $past(chipSelectNFirst)) else $error("addr moved");
    addr_hold_a: assert property (!chipSelectNFirst &&
        !$past(chipSelectNFirst) |-> $stable(wordSelect)) else $error("addr");
    read_dir_a: assert property ($rose(direction) |->
        chipSelectNFirst && $past(chipSelectNFirst)) else $error("dir rose");
    data_end_a: assert property ($rose(chipSelectNFirst) &&
        !direction |-> $stable(dataIn)) else $error("data moved");
    strobe_dir_a: assert property ($fell(chipSelectNFirst) &&
        !direction |-> !direction [*2]) else $error("short strobe");
    rmw_turn_a: assert property ($fell(direction) &&
        !chipSelectNFirst |-> !$past(chipSelectNFirst)) else $error("rmw");
endmodule // sram_host_checker
bind sram_host sram_host_checker chk (
    .sys_clk(sys_clk),
    .srst(srst),
    .wordSelect(wordSelect),
    .dataIn(dataIn),
    .direction(direction),
    .chipSelectNFirst(chipSelectNFirst)
);

// *** verif/sram_cell_model.sv ***
`timescale 1ns/1ps
module sram_cell_model (
    input wire [7:0] wordSelect,
    input wire dataIn,
    input wire direction,
    input wire chipSelectNFirst,
    input wire chipSelectNSecond,
    input wire chipSelectNThird,
    output reg memOut,
    output wire memOutEnN
);
    reg cells [0:255];
    wire selected = !(chipSelectNFirst | chipSelectNSecond | chipSelectNThird);
    assign memOutEnN = !(selected && direction);
    always @(wordSelect, dataIn, direction, selected)
        if (selected && !direction) cells[wordSelect] <= dataIn;
    // Released line shows the stored bit, not its inverse, so stale reads cannot pass
    always @(wordSelect, memOutEnN)
        if (!memOutEnN) memOut = !cells[wordSelect];
        else memOut = cells[wordSelect];
endmodule // sram_cell_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    reg sys_clk = 0, srst = 1, reqValid = 0, reqData = 0;
    reg [1:0] reqOp = 2'h0;
    reg [7:0] reqAddr = 8'h00;
    wire reqReady, rspValid, rspData, dataIn, direction, memOut, memOutEnN;
    wire chipSelectNFirst, chipSelectNSecond, chipSelectNThird;
    wire [7:0] wordSelect;
    integer errCount = 0, checks = 0, cyc = 0;
    always #12.5 sys_clk = ~sys_clk;
    sram_host #(.SETUP_CYC(1), .STROBE_CYC(1), .HOLD_CYC(1),
        .ACCESS_CYC(1)) dut (
        .sys_clk(sys_clk),
        .srst(srst),
        .reqValid(reqValid),
        .reqOp(reqOp),
        .reqAddr(reqAddr),
        .reqData(reqData),
        .reqReady(reqReady),
        .rspValid(rspValid),
        .rspData(rspData),
        .wordSelect(wordSelect),
        .dataIn(dataIn),
        .direction(direction),
        .chipSelectNFirst(chipSelectNFirst),
        .chipSelectNSecond(chipSelectNSecond),
        .chipSelectNThird(chipSelectNThird),
        .memOut(memOut),
        .memOutEnN(memOutEnN)
    );
    sram_cell_model mem (
        .wordSelect(wordSelect),
        .dataIn(dataIn),
        .direction(direction),
        .chipSelectNFirst(chipSelectNFirst),
        .chipSelectNSecond(chipSelectNSecond),
        .chipSelectNThird(chipSelectNThird),
        .memOut(memOut),
        .memOutEnN(memOutEnN)
    );
    task stop_test;
        begin
            if (errCount == 0 && checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input got, input exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errCount = errCount + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task acc(input [1:0] op, input [7:0] a, input d);
        integer n;
        begin
            @(negedge sys_clk);
            reqValid = 1'h1;
            reqOp = op;
            reqAddr = a;
            reqData = d;
            // Ready seen at a falling edge is taken at the next rising one
            while (reqReady !== 1'h1) @(negedge sys_clk);
            @(negedge sys_clk);
            reqValid = 1'h0;
            n = 0;
            while (rspValid !== 1'h1 && n < 20) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            chk(rspValid, 1'h1);
            chk(chipSelectNFirst, 1'h1);
            chk(direction, 1'h1);
        end
    endtask
    task t_write_read;
        begin
            acc(2'h1, 8'h5A, 1'h1);
            acc(2'h0, 8'h5A, 1'h0);
            chk(rspData, 1'h1);
            acc(2'h1, 8'h5A, 1'h0);
            acc(2'h3, 8'h5A, 1'h1);
            chk(rspData, 1'h0);
        end
    endtask
    task t_decode;
        begin
            acc(2'h1, 8'h00, 1'h1);
            acc(2'h1, 8'hFF, 1'h0);
            acc(2'h1, 8'h80, 1'h1);
            acc(2'h0, 8'h00, 1'h0);
            chk(rspData, 1'h1);
            acc(2'h0, 8'hFF, 1'h1);
            chk(rspData, 1'h0);
            acc(2'h0, 8'hFF, 1'h1);
            chk(rspData, 1'h0);
        end
    endtask
    task t_rmw;
        begin
            acc(2'h2, 8'h80, 1'h0);
            chk(rspData, 1'h1);
            acc(2'h0, 8'h80, 1'h1);
            chk(rspData, 1'h0);
        end
    endtask
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            errCount = errCount + 1;
            stop_test;
        end
    end
    initial begin
        repeat (3) @(negedge sys_clk);
        srst = 1'h0;
        t_write_read;
        t_decode;
        t_rmw;
        stop_test;
    end
endmodule // tb_top
